// ===== verilog/wac_write_addr.v
`timescale 1ns/1ps
// Function
// RULE1: write bursts always use incrementing burst kind
// RULE2: cache attr from memory type, outer policy
// RULE3: beat count field gives beats, sixteen max
// RULE4: hint bits: early response, zeros, evictions
// RULE5: inner type code in hints, bit0 shareable
// RULE6: handshakes advance only when qualifier high
// RULE7: beat size codes 8 to 64 bits
`include "wac_defines.vh"

module wac_write_addr (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bus_clock_qualifier,
    output reg  [31:0] write_addr_addr,
    output reg  [1:0]  write_addr_burst_kind,
    output reg  [3:0]  write_addr_cache_attr,
    output reg  [1:0]  write_addr_id,
    output reg  [3:0]  write_addr_beat_count,
    output reg  [1:0]  write_addr_lock,
    output reg  [2:0]  write_addr_prot,
    output reg  [2:0]  write_addr_beat_size,
    output reg  [8:0]  write_addr_user_hints,
    output reg         write_addr_valid,
    input  wire        write_addr_ready
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [3:0] mem_code;
    input [1:0] mem;
    input [1:0] pol;
    begin
        if (mem == `WAC_MEM_SO)
            mem_code = `WAC_TYPE_SO;
        else if (mem == `WAC_MEM_DEV)
            mem_code = `WAC_TYPE_DEV;
        else begin
            case (pol)
                `WAC_POL_NC: mem_code = `WAC_TYPE_NC;
                `WAC_POL_WT: mem_code = `WAC_TYPE_WT;
                `WAC_POL_WB: mem_code = `WAC_TYPE_WB;
                default:     mem_code = `WAC_TYPE_WBWA;
            endcase
        end
    end
endfunction

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    end
endfunction

localparam SEL_ADDR = 0;
localparam SEL_ATTR = 1;
localparam SEL_CTRL = 2;
localparam SEL_STAT = 3;

function [3:0] reg_sel;
    input [7:0] addr;
    begin
        reg_sel = 4'h0;
        case (addr)
            `WAC_OFF_ADDR:   reg_sel[SEL_ADDR] = 1'b1;
            `WAC_OFF_ATTR:   reg_sel[SEL_ATTR] = 1'b1;
            `WAC_OFF_CTRL:   reg_sel[SEL_CTRL] = 1'b1;
            `WAC_OFF_STATUS: reg_sel[SEL_STAT] = 1'b1;
            default:         reg_sel = 4'h0;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// register bus write path
// ----------------------------------------------------------------
reg  [7:0]  wr_addr_q;
reg         wr_addr_ok_q;
reg  [31:0] wr_data_q;
reg  [3:0]  wr_strb_q;
reg         wr_data_ok_q;
reg  [31:0] addr_reg_q;
reg  [31:0] attr_reg_q;
reg         req_q;
reg         ovrun_q;
reg         badsz_q;
reg  [7:0]  count_q;

wire [3:0]  wr_sel  = reg_sel(wr_addr_q);
wire        aw_take = s_axi_awvalid & s_axi_awready;
wire        w_take  = s_axi_wvalid & s_axi_wready;
wire        wr_go   = wr_addr_ok_q & wr_data_ok_q & ~s_axi_bvalid;
wire        hs_done = write_addr_valid & write_addr_ready & bus_clock_qualifier;
wire        wr_ctrl = wr_go & wr_sel[SEL_CTRL] & wr_strb_q[0];
wire        issue   = wr_ctrl & wr_data_q[`WAC_CTRL_ISSUE];
wire        clr     = wr_ctrl & wr_data_q[`WAC_CTRL_CLR];
wire        busy    = req_q | write_addr_valid;
wire        wr_hit  = |wr_sel;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        wr_addr_ok_q  <= 1'b0;
        wr_data_ok_q  <= 1'b0;
        wr_addr_q     <= 8'h00;
        wr_data_q     <= 32'h0000_0000;
        wr_strb_q     <= 4'h0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `WAC_RESP_OKAY;
    end else begin
        if (aw_take) begin
            wr_addr_q     <= s_axi_awaddr;
            wr_addr_ok_q  <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (w_take) begin
            wr_data_q    <= s_axi_wdata;
            wr_strb_q    <= s_axi_wstrb;
            wr_data_ok_q <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `WAC_RESP_OKAY : `WAC_RESP_SLVERR;
            wr_addr_ok_q <= 1'b0;
            wr_data_ok_q <= 1'b0;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        addr_reg_q <= 32'h0000_0000;
        attr_reg_q <= `WAC_RST_ATTR;
    end else if (wr_go) begin
        if (wr_sel[SEL_ADDR])
            addr_reg_q <= merge(addr_reg_q, wr_data_q, wr_strb_q);
        if (wr_sel[SEL_ATTR])
            attr_reg_q <= merge(attr_reg_q, wr_data_q, wr_strb_q);
    end
end

// ----------------------------------------------------------------
// attribute fields
// ----------------------------------------------------------------
wire [3:0] attr_len   = attr_reg_q[`WAC_LEN_LSB +: 4];
wire [2:0] attr_size  = attr_reg_q[`WAC_SIZE_LSB +: 3];
wire [1:0] mem_t      = attr_reg_q[`WAC_MEM_LSB +: 2];
wire [1:0] attr_outer = attr_reg_q[`WAC_OUTER_LSB +: 2];
wire [1:0] attr_inner = attr_reg_q[`WAC_INNER_LSB +: 2];
wire       attr_share = attr_reg_q[`WAC_SHARE_BIT];
wire [1:0] attr_id    = attr_reg_q[`WAC_ID_LSB +: 2];
wire [1:0] attr_lock  = attr_reg_q[`WAC_LOCK_LSB +: 2];
wire [2:0] attr_prot  = attr_reg_q[`WAC_PROT_LSB +: 3];
wire       bad_size   = attr_size[2];                               // [RULE7]

// ----------------------------------------------------------------
// request, overrun and size-error flags
// ----------------------------------------------------------------

always @(posedge aclk) begin
    if (!aresetn) begin
        req_q   <= 1'b0;
        ovrun_q <= 1'b0;
        badsz_q <= 1'b0;
    end else begin
        if (issue & ~busy & ~bad_size)
            req_q <= 1'b1;
        else if (req_q & bus_clock_qualifier)
            req_q <= 1'b0;                                          // [RULE6]
        if (issue & busy)
            ovrun_q <= 1'b1;
        else if (clr)
            ovrun_q <= 1'b0;
        if (issue & ~busy & bad_size)
            badsz_q <= 1'b1;                                        // [RULE7]
        else if (clr)
            badsz_q <= 1'b0;
    end
end

// ----------------------------------------------------------------
// write address channel
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        write_addr_valid      <= 1'b0;
        write_addr_addr       <= 32'h0000_0000;
        write_addr_burst_kind <= `WAC_BURST_INCR;
        write_addr_cache_attr <= 4'h0;
        write_addr_id         <= 2'h0;
        write_addr_beat_count <= 4'h0;
        write_addr_lock       <= 2'h0;
        write_addr_prot       <= 3'h0;
        write_addr_beat_size  <= 3'h0;
        write_addr_user_hints <= 9'h000;
    end else if (bus_clock_qualifier) begin                         // [RULE6]
        if (req_q & ~write_addr_valid) begin
            write_addr_valid      <= 1'b1;
            write_addr_addr       <= addr_reg_q;
            write_addr_burst_kind <= `WAC_BURST_INCR;               // [RULE1]
            write_addr_cache_attr <= mem_code(mem_t, attr_outer);   // [RULE2]
            write_addr_id         <= attr_id;
            write_addr_beat_count <= attr_len;                      // [RULE3]
            write_addr_lock       <= attr_lock;
            write_addr_prot       <= attr_prot;
            write_addr_beat_size  <= attr_size;                     // [RULE7]
            write_addr_user_hints <= {attr_reg_q[`WAC_EARLY_BIT],
                                      attr_reg_q[`WAC_ZERO_BIT],
                                      attr_reg_q[`WAC_CLEAN_BIT],
                                      attr_reg_q[`WAC_L1EV_BIT],    // [RULE4]
                                      mem_code(mem_t, attr_inner),
                                      attr_share};                  // [RULE5]
        end else if (hs_done) begin
            write_addr_valid <= 1'b0;                               // [RULE6]
        end
    end
end

// ----------------------------------------------------------------
// burst counter
// ----------------------------------------------------------------
wire [7:0] count_d = count_q + 8'h01;

always @(posedge aclk) begin
    if (!aresetn)
        count_q <= 8'h00;
    else if (hs_done)
        count_q <= count_d;                                         // [RULE6]
end

// ----------------------------------------------------------------
// register bus read path
// ----------------------------------------------------------------
reg [31:0] rd_val;
reg        rd_hit;
wire [3:0] rd_sel = reg_sel(s_axi_araddr);

always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = |rd_sel;
    case (s_axi_araddr)
        `WAC_OFF_ADDR:   rd_val = addr_reg_q;
        `WAC_OFF_ATTR:   rd_val = attr_reg_q;
        `WAC_OFF_CTRL:   rd_val = 32'h0000_0000;
        `WAC_OFF_STATUS: begin
            rd_val[`WAC_ST_BUSY]        = busy;
            rd_val[`WAC_ST_OVRUN]       = ovrun_q;
            rd_val[`WAC_ST_BADSZ]       = badsz_q;
            rd_val[`WAC_ST_CNT_LSB +: 8] = count_q;
        end
        default:         rd_val = 32'h0000_0000;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `WAC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? `WAC_RESP_OKAY : `WAC_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule // wac_write_addr

// ===== verilog/wac_defines.vh
`ifndef WAC_DEFINES_VH
`define WAC_DEFINES_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WAC_OFF_ADDR    8'h00
`define WAC_OFF_ATTR    8'h04
`define WAC_OFF_CTRL    8'h08
`define WAC_OFF_STATUS  8'h0c
// ----------------------------------------------------------------
// attribute register fields
// ----------------------------------------------------------------
`define WAC_LEN_LSB     0
`define WAC_SIZE_LSB    4
`define WAC_MEM_LSB     8
`define WAC_OUTER_LSB   10
`define WAC_INNER_LSB   12
`define WAC_SHARE_BIT   14
`define WAC_EARLY_BIT   15
`define WAC_ZERO_BIT    16
`define WAC_CLEAN_BIT   17
`define WAC_L1EV_BIT    18
`define WAC_ID_LSB      20
`define WAC_LOCK_LSB    24
`define WAC_PROT_LSB    28
// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define WAC_CTRL_ISSUE  0
`define WAC_CTRL_CLR    1
`define WAC_ST_BUSY     0
`define WAC_ST_OVRUN    1
`define WAC_ST_BADSZ    2
`define WAC_ST_CNT_LSB  8
// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define WAC_BURST_INCR  2'h1
`define WAC_MEM_SO      2'h0
`define WAC_MEM_DEV     2'h1
`define WAC_POL_NC      2'h0
`define WAC_POL_WT      2'h1
`define WAC_POL_WB      2'h2
`define WAC_POL_WBWA    2'h3
`define WAC_TYPE_SO     4'h0
`define WAC_TYPE_DEV    4'h1
`define WAC_TYPE_NC     4'h3
`define WAC_TYPE_WT     4'h6
`define WAC_TYPE_WB     4'h7
`define WAC_TYPE_WBWA   4'hf
`define WAC_RESP_OKAY   2'h0
`define WAC_RESP_SLVERR 2'h2
`define WAC_RST_ATTR    32'h0000_0030
`endif

// ===== test/wac_write_addr_chk.sv
`timescale 1ns/1ps
// ----
// write address checker
// ----
module wac_write_addr_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        bus_clock_qualifier,
    input wire        write_addr_valid,
    input wire        write_addr_ready,
    input wire [31:0] write_addr_addr,
    input wire [1:0]  write_addr_burst_kind,
    input wire [3:0]  write_addr_cache_attr,
    input wire [3:0]  write_addr_beat_count,
    input wire [2:0]  write_addr_beat_size,
    input wire [8:0]  write_addr_user_hints
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire        take = write_addr_valid && write_addr_ready && bus_clock_qualifier;
    wire [53:0] pay  = {write_addr_addr, write_addr_burst_kind, write_addr_cache_attr, write_addr_beat_count,
                        write_addr_beat_size, write_addr_user_hints};
    wire [3:0]  inr  = write_addr_user_hints[4:1];
    sequence s_wait;
        write_addr_valid && !take;
    endsequence
    sequence s_hold;
        write_addr_valid && $stable(pay);
    endsequence
    kind_fixed_a: assert property (write_addr_burst_kind == 2'h1)
        else $error("burst kind not incrementing");
    payload_hold_a: assert property (s_wait |=> s_hold)
        else $error("address dropped or changed before take");
    qual_freeze_a: assert property (!bus_clock_qualifier |=> $stable(write_addr_valid))
        else $error("valid moved on unqualified edge");
    take_drop_a: assert property (take |=> !write_addr_valid)
        else $error("valid stayed after take");
    size_legal_a: assert property (write_addr_valid |-> write_addr_beat_size <= 3'h3)
        else $error("beat size code out of range");
    cache_code_a: assert property (write_addr_valid |->
        write_addr_cache_attr inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hf})
        else $error("cache attr code illegal");
    inner_code_a: assert property (write_addr_valid |-> inr inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hf})
        else $error("inner type code illegal");
    type_match_a: assert property (write_addr_valid && inr <= 4'h1 |-> write_addr_cache_attr == inr)
        else $error("memory type differs between cache attr and hints");
endmodule // wac_write_addr_chk

bind wac_write_addr wac_write_addr_chk wac_write_addr_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .bus_clock_qualifier(bus_clock_qualifier), .write_addr_valid(write_addr_valid),
    .write_addr_ready(write_addr_ready), .write_addr_addr(write_addr_addr),
    .write_addr_burst_kind(write_addr_burst_kind), .write_addr_cache_attr(write_addr_cache_attr),
    .write_addr_beat_count(write_addr_beat_count), .write_addr_beat_size(write_addr_beat_size),
    .write_addr_user_hints(write_addr_user_hints));

// ===== test/wac_slave_model.sv
`timescale 1ns/1ps
// ----
// address slave with programmable stall
// ----
module wac_slave_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       bus_clock_qualifier,
    input  wire       write_addr_valid,
    input  wire [3:0] stall,
    output reg        write_addr_ready
);
    reg [3:0] wait_q;
    always @(posedge aclk) begin
        if (!aresetn || !write_addr_valid || (write_addr_ready && bus_clock_qualifier)) begin
            wait_q <= 4'h0;
            write_addr_ready <= 1'b0;
        end else begin
            if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
            write_addr_ready <= (wait_q >= stall);
        end
    end
endmodule // wac_slave_model

// ===== test/wac_write_addr_tb_top.sv
`timescale 1ns/1ps
`include "wac_defines.vh"
// ----
// write address bench
// ----
module wac_write_addr_tb_top;
    reg         aclk, aresetn, awv, wv, bry, arv, rry, qual;
    reg  [7:0]  awa, ara;
    reg  [31:0] wd, at;
    reg  [3:0]  stall;
    reg  [1:0]  ratio, div, me, ou, inr;
    reg  [4:0]  fl;
    wire        awr, wr, bv, arr, rv, rdy, vld;
    wire [1:0]  br, rr, bk, id, lk;
    wire [31:0] rd, ad;
    wire [3:0]  ca, bc;
    wire [2:0]  pr, bs;
    wire [8:0]  uh;
    integer     n_mismatch, total_checks, cyc, i;
    wac_write_addr wac_write_addr_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .bus_clock_qualifier(qual), .write_addr_addr(ad), .write_addr_burst_kind(bk), .write_addr_cache_attr(ca),
        .write_addr_id(id), .write_addr_beat_count(bc), .write_addr_lock(lk), .write_addr_prot(pr),
        .write_addr_beat_size(bs), .write_addr_user_hints(uh), .write_addr_valid(vld), .write_addr_ready(rdy));
    wac_slave_model wac_slave_model_inst (.aclk(aclk), .aresetn(aresetn), .bus_clock_qualifier(qual),
        .write_addr_valid(vld), .stall(stall), .write_addr_ready(rdy));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        div <= (div >= ratio - 2'h1) ? 2'h0 : div + 2'h1;
        qual <= (div == 2'h0);
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
                n_mismatch = n_mismatch + 1;
            end
        end
    endtask
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            bry <= 1'b1;
            do begin
                @(posedge aclk);
                if (awr === 1'b1) awv <= 1'b0;
                if (wr === 1'b1) wv <= 1'b0;
            end while (bv !== 1'b1);
            bry <= 1'b0;
            chk({30'h0, br}, {30'h0, er});
        end
    endtask
    task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
        begin
            @(posedge aclk);
            ara <= a;
            arv <= 1'b1;
            rry <= 1'b1;
            do begin
                @(posedge aclk);
                if (arr === 1'b1) arv <= 1'b0;
            end while (rv !== 1'b1);
            rry <= 1'b0;
            chk(rd, ed);
            chk({30'h0, rr}, {30'h0, er});
        end
    endtask
    function [3:0] code(input [1:0] m, input [1:0] p);
        code = (m == 2'h0) ? 4'h0 : (m == 2'h1) ? 4'h1 : (p == 2'h0) ? 4'h3 : (p == 2'h1) ? 4'h6 :
               (p == 2'h2) ? 4'h7 : 4'hf;
    endfunction
    task burst(input [31:0] a, input [3:0] ec, input [8:0] eh);
        begin
            axw(`WAC_OFF_ADDR, ~a, `WAC_RESP_OKAY);
            axw(`WAC_OFF_ATTR, a, `WAC_RESP_OKAY);
            axw(`WAC_OFF_CTRL, 32'h1, `WAC_RESP_OKAY);
            while (!(vld === 1'b1 && rdy === 1'b1 && qual === 1'b1) && cyc < 19000) @(posedge aclk);
            chk({31'h0, vld}, 32'h1);
            chk(ad, ~a);
            chk({30'h0, id}, {30'h0, a[21:20]});
            chk({30'h0, lk}, {30'h0, a[25:24]});
            chk({29'h0, pr}, {29'h0, a[30:28]});
            chk({30'h0, bk}, 32'h1);
            chk({28'h0, ca}, {28'h0, ec});
            chk({28'h0, bc}, {28'h0, a[3:0]});
            chk({29'h0, bs}, {29'h0, a[6:4]});
            chk({23'h0, uh}, {23'h0, eh});
        end
    endtask
    task t_reset;
        begin
            axr(`WAC_OFF_ATTR, `WAC_RST_ATTR, `WAC_RESP_OKAY);
            axr(`WAC_OFF_STATUS, 32'h0, `WAC_RESP_OKAY);
            chk({30'h0, bk}, 32'h1);
        end
    endtask
    task t_attr;
        for (i = 0; i < 8; i = i + 1) begin
            ratio <= i % 3 + 1;
            stall <= i;
            me = (i < 2) ? i[1:0] : {1'b1, i[0]};
            ou = i[1:0];
            inr = i[1:0] + 2'h1;
            fl = i[0] ? 5'h15 : 5'h0a;
            at = {1'b0, i[2:0], 2'b0, i[1:0], 2'b0, i[1:0], 1'b0, fl, inr, ou, me, 1'b0, 1'b0, i[1:0], i[2:0], i[0]};
            burst(at, code(me, ou), {fl[1], fl[2], fl[3], fl[4], code(me, inr), fl[0]});
        end
    endtask
    task t_refuse;
        begin
            ratio <= 2'h1;
            axw(`WAC_OFF_ATTR, 32'h40, `WAC_RESP_OKAY);
            axw(`WAC_OFF_CTRL, 32'h1, `WAC_RESP_OKAY);
            axr(`WAC_OFF_STATUS, 32'h0804, `WAC_RESP_OKAY);
            stall <= 4'hf;
            axw(`WAC_OFF_ATTR, 32'h30, `WAC_RESP_OKAY);
            axw(`WAC_OFF_CTRL, 32'h1, `WAC_RESP_OKAY);
            axw(`WAC_OFF_CTRL, 32'h1, `WAC_RESP_OKAY);
            axr(`WAC_OFF_STATUS, 32'h0807, `WAC_RESP_OKAY);
            while (vld !== 1'b0) @(posedge aclk);
            axw(`WAC_OFF_CTRL, 32'h2, `WAC_RESP_OKAY);
            axr(`WAC_OFF_STATUS, 32'h0900, `WAC_RESP_OKAY);
            axw(8'h10, 32'h1, `WAC_RESP_SLVERR);
            axr(8'h10, 32'h0, `WAC_RESP_SLVERR);
            axr(`WAC_OFF_CTRL, 32'h0, `WAC_RESP_OKAY);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        {aresetn, awv, wv, bry, arv, rry, qual, awa, ara, wd, stall, div} = 0;
        ratio = 2'h1;
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_attr;
        t_refuse;
        stop_test;
    end
endmodule // wac_write_addr_tb_top
